// File: logic/spl_stream_splitter.sv
/*
 * Stream splitter: fans one ready/valid source out to up to sixteen sinks
 * with no latency, plus a small status port with beat and stall counters.
 * Assumes source and sinks share clk_sys and use a ready latency of zero.
 */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps

module spl_stream_splitter
    import spl_pkg::*;
#(
    parameter int OUTPUT_COUNT = 2,
    parameter bit QUALIFY_VALID = 1'b1,
    parameter int DATA_W = 8,
    parameter int SYMBOL_W = 8,
    parameter bit USE_PACKETS = 1'b0,
    parameter bit USE_CHANNEL = 1'b0,
    parameter int CHANNEL_W = 1,
    parameter int MAX_CHANNELS = 1,
    parameter bit USE_ERROR = 1'b0,
    parameter int ERROR_W = 1,
    localparam int SYMBOLS = DATA_W / SYMBOL_W,
    localparam int EMPTY_W = (SYMBOLS > 1) ? $clog2(SYMBOLS) : 0,
    localparam int PKT_W = USE_PACKETS ? (2 + EMPTY_W) : 0,
    localparam int CH_W = USE_CHANNEL ? CHANNEL_W : 0,
    localparam int ER_W = USE_ERROR ? ERROR_W : 0,
    localparam int BEAT_W = DATA_W + PKT_W + CH_W + ER_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [BEAT_W-1:0] in_beat,
    output logic in_ready,
    output logic [OUTPUT_COUNT-1:0] out_valid,
    output logic [OUTPUT_COUNT-1:0][BEAT_W-1:0] out_beat,
    input wire logic [OUTPUT_COUNT-1:0] out_ready,
    input wire spl_reg_req_t reg_req,
    output logic [SPL_WORD_W-1:0] reg_rdata
);

    // ************************************************************
    // Fan-out
    // ************************************************************
    // The beat vector only holds the fields that are switched on, so a
    // disabled option costs no wires on either side.
    localparam int BEAT_BITS = BEAT_W;

    logic [OUTPUT_COUNT-1:0] others_ready;

    assign in_ready = &out_ready;

    genvar gi;
    generate
        for (gi = 0; gi < OUTPUT_COUNT; gi++) begin : g_lane
            localparam logic [OUTPUT_COUNT-1:0] SELF =
                OUTPUT_COUNT'(1) << gi;

            assign others_ready[gi] = &(out_ready | SELF);

            spl_lane #(
                .BEAT_W(BEAT_BITS),
                .QUALIFY(QUALIFY_VALID)
            ) u_lane (
                .in_valid(in_valid),
                .in_beat(in_beat),
                .others_ready(others_ready[gi]),
                .out_valid(out_valid[gi]),
                .out_beat(out_beat[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Status port
    // ************************************************************
    // Counters only watch the stream; nothing here feeds back into it.
    spl_state_t st_q;
    spl_state_t st_d;

    logic beat_taken;
    logic beat_stalled;
    logic ctrl_write;
    logic clear_req;
    logic [SPL_WORD_W-1:0] config_word;
    logic [SPL_WORD_W-1:0] live_word;

    assign beat_taken = in_valid & in_ready;
    assign beat_stalled = in_valid & ~in_ready;
    assign ctrl_write = reg_req.we & (reg_req.addr == SPL_OFS_CTRL);
    assign clear_req = ctrl_write & reg_req.wdata[SPL_CTRL_CLEAR_BIT];

    always_comb begin
        config_word = '0;
        config_word[SPL_CFG_COUNT_LSB +: 5] = 5'(OUTPUT_COUNT);
        config_word[SPL_CFG_QUALIFY_BIT] = QUALIFY_VALID;
        config_word[SPL_CFG_PACKETS_BIT] = USE_PACKETS;
        config_word[SPL_CFG_CHANNEL_BIT] = USE_CHANNEL;
        config_word[SPL_CFG_ERROR_BIT] = USE_ERROR;
        config_word[SPL_CFG_CHAN_W_LSB +: 4] = 4'(CH_W);
        config_word[SPL_CFG_ERR_W_LSB +: 5] = 5'(ER_W);
        config_word[SPL_CFG_MAX_CH_LSB +: 8] =
            USE_CHANNEL ? 8'(MAX_CHANNELS) : 8'h00;
    end

    always_comb begin
        live_word = '0;
        live_word[OUTPUT_COUNT-1:0] = out_ready;
        live_word[SPL_LIVE_VALID_BIT] = in_valid;
        live_word[SPL_LIVE_READY_BIT] = in_ready;
    end

    always_comb begin
        st_d = st_q;
        if (ctrl_write) begin
            st_d.count_en = reg_req.wdata[SPL_CTRL_COUNT_EN_BIT];
        end
        // A beat in the clearing cycle is counted, not lost.
        if (clear_req) begin
            st_d.beat_cnt = SPL_RST_COUNTER;
            st_d.stall_cnt = SPL_RST_COUNTER;
        end
        if (st_q.count_en && beat_taken) begin
            st_d.beat_cnt = st_d.beat_cnt + 32'h0000_0001;
        end
        if (st_q.count_en && beat_stalled) begin
            st_d.stall_cnt = st_d.stall_cnt + 32'h0000_0001;
        end
        st_d.rdata = SPL_RST_RDATA;
        if (reg_req.re) begin
            case (reg_req.addr)
                SPL_OFS_CONFIG: st_d.rdata = config_word;
                SPL_OFS_CTRL: st_d.rdata = {31'h0000_0000, st_q.count_en};
                SPL_OFS_BEATS: st_d.rdata = st_q.beat_cnt;
                SPL_OFS_STALLS: st_d.rdata = st_q.stall_cnt;
                SPL_OFS_LIVE: st_d.rdata = live_word;
                default: st_d.rdata = SPL_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q.count_en <= SPL_RST_COUNT_EN;
            st_q.beat_cnt <= SPL_RST_COUNTER;
            st_q.stall_cnt <= SPL_RST_COUNTER;
            st_q.rdata <= SPL_RST_RDATA;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_ready_and;
        in_ready == &out_ready;
    endproperty
    a_ready_and: assert property (p_ready_and)
        else $error("source ready is not the AND of sink readies");

    property p_stall_reaches_source;
        (out_ready != {OUTPUT_COUNT{1'b1}}) |-> !in_ready;
    endproperty
    a_stall_reaches_source: assert property (p_stall_reaches_source)
        else $error("a stalled sink did not stall the source");

    property p_no_latency;
        $rose(in_valid) && (&out_ready) |-> out_valid[0];
    endproperty
    a_no_latency: assert property (p_no_latency)
        else $error("valid took a cycle to reach the first output");

    property p_count_beat;
        st_q.count_en && beat_taken && !clear_req
            |=> st_q.beat_cnt == $past(st_q.beat_cnt) + 32'h0000_0001;
    endproperty
    a_count_beat: assert property (p_count_beat)
        else $error("taken beat was not counted");

    property p_read_once;
        !reg_req.re |=> reg_rdata == SPL_RST_RDATA;
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("read data held past its cycle");

    generate
        for (gi = 0; gi < OUTPUT_COUNT; gi++) begin : g_chk
            property p_beat_copy;
                out_beat[gi] == in_beat;
            endproperty
            a_beat_copy: assert property (p_beat_copy)
                else $error("output beat differs from input beat");

            if (QUALIFY_VALID) begin : g_gate
                property p_gated;
                    in_valid && !others_ready[gi] |-> !out_valid[gi];
                endproperty
                a_gated: assert property (p_gated)
                    else $error("valid not gated by a stall elsewhere");

                property p_pass;
                    others_ready[gi] |-> out_valid[gi] == in_valid;
                endproperty
                a_pass: assert property (p_pass)
                    else $error("valid lost while the others were ready");
            end else begin : g_free
                property p_free;
                    out_valid[gi] == in_valid;
                endproperty
                a_free: assert property (p_free)
                    else $error("ungated valid does not follow input");
            end
        end
    endgenerate

    // ************************************************************
    // Counter checks
    // ************************************************************
    // The counters share the flops with the enable and the read data; here stall counting,
    // beat clear and hold, enable writes and reads of the beat and control words are pinned down; beat counting is checked above.
    property p_count_stall;
        st_q.count_en && beat_stalled && !clear_req
            |=> st_q.stall_cnt == $past(st_q.stall_cnt) + 32'h0000_0001;
    endproperty
    a_count_stall: assert property (p_count_stall)
        else $error("stalled cycle was not counted");

    property p_clear_idle;
        clear_req && !beat_taken |=> st_q.beat_cnt == SPL_RST_COUNTER;
    endproperty
    a_clear_idle: assert property (p_clear_idle)
        else $error("beat counter survived a clear");

    property p_clear_with_beat;
        clear_req && beat_taken && st_q.count_en
            |=> st_q.beat_cnt == 32'h0000_0001;
    endproperty
    a_clear_with_beat: assert property (p_clear_with_beat)
        else $error("beat taken during a clear was lost");

    property p_hold_when_off;
        !st_q.count_en && !clear_req |=> $stable(st_q.beat_cnt);
    endproperty
    a_hold_when_off: assert property (p_hold_when_off)
        else $error("beat counter moved while counting was off");

    property p_ctrl_write;
        ctrl_write
            |=> st_q.count_en == $past(reg_req.wdata[SPL_CTRL_COUNT_EN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("count enable did not take the written value");

    property p_read_beats;
        reg_req.re && (reg_req.addr == SPL_OFS_BEATS)
            |=> reg_rdata == $past(st_q.beat_cnt);
    endproperty
    a_read_beats: assert property (p_read_beats)
        else $error("beat count read back wrong");

    property p_read_ctrl;
        reg_req.re && (reg_req.addr == SPL_OFS_CTRL)
            |=> reg_rdata == {31'h0000_0000, $past(st_q.count_en)};
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control word read back wrong");

    property p_cov_accept;
        in_valid && in_ready;
    endproperty
    c_cov_accept: cover property (p_cov_accept);

    property p_cov_stall_then_go;
        beat_stalled ##1 beat_taken;
    endproperty
    c_cov_stall_then_go: cover property (p_cov_stall_then_go);

    property p_cov_clear;
        clear_req && beat_taken;
    endproperty
    c_cov_clear: cover property (p_cov_clear);

    property p_cov_one_stall;
        in_valid && ($countones(out_ready) == OUTPUT_COUNT - 1);
    endproperty
    c_cov_one_stall: cover property (p_cov_one_stall);

    property p_cov_read_beats;
        reg_req.re && (reg_req.addr == SPL_OFS_BEATS) ##1 reg_rdata != '0;
    endproperty
    c_cov_read_beats: cover property (p_cov_read_beats);

endmodule // spl_stream_splitter

// File: logic/spl_pkg.sv
/*
 * Package of the stream splitter: status port carrier, register offsets,
 * field positions and reset values.
 * Assumes a single 125 MHz clock domain and a synchronous status master.
 */
package spl_pkg;

    // ************************************************************
    // Clock
    // ************************************************************
    localparam int SPL_CLK_PERIOD_NS = 8;

    // ************************************************************
    // Status port carrier
    // ************************************************************
    localparam int SPL_ADDR_W = 8;
    localparam int SPL_WORD_W = 32;

    typedef struct packed {
        logic we;
        logic re;
        logic [SPL_ADDR_W-1:0] addr;
        logic [SPL_WORD_W-1:0] wdata;
    } spl_reg_req_t;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [SPL_ADDR_W-1:0] SPL_OFS_CONFIG = 8'h00;
    localparam logic [SPL_ADDR_W-1:0] SPL_OFS_CTRL = 8'h04;
    localparam logic [SPL_ADDR_W-1:0] SPL_OFS_BEATS = 8'h08;
    localparam logic [SPL_ADDR_W-1:0] SPL_OFS_STALLS = 8'h0c;
    localparam logic [SPL_ADDR_W-1:0] SPL_OFS_LIVE = 8'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SPL_CFG_COUNT_LSB = 0;
    localparam int SPL_CFG_QUALIFY_BIT = 8;
    localparam int SPL_CFG_PACKETS_BIT = 9;
    localparam int SPL_CFG_CHANNEL_BIT = 10;
    localparam int SPL_CFG_ERROR_BIT = 11;
    localparam int SPL_CFG_CHAN_W_LSB = 12;
    localparam int SPL_CFG_ERR_W_LSB = 16;
    localparam int SPL_CFG_MAX_CH_LSB = 24;
    localparam int SPL_CTRL_COUNT_EN_BIT = 0;
    localparam int SPL_CTRL_CLEAR_BIT = 1;
    localparam int SPL_LIVE_VALID_BIT = 16;
    localparam int SPL_LIVE_READY_BIT = 17;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic SPL_RST_COUNT_EN = 1'b1;
    localparam logic [SPL_WORD_W-1:0] SPL_RST_COUNTER = 32'h0000_0000;
    localparam logic [SPL_WORD_W-1:0] SPL_RST_RDATA = 32'h0000_0000;

    // ************************************************************
    // Block state
    // ************************************************************
    typedef struct packed {
        logic count_en;
        logic [SPL_WORD_W-1:0] beat_cnt;
        logic [SPL_WORD_W-1:0] stall_cnt;
        logic [SPL_WORD_W-1:0] rdata;
    } spl_state_t;

endpackage

// File: logic/spl_lane.sv
/*
 * One output lane of the stream splitter: copies the beat and qualifies
 * valid with the readiness of the other lanes.
 * Assumes the caller works out the AND of the other lanes' ready.
 */
`timescale 1ns/100ps

module spl_lane #(
    parameter int BEAT_W = 8,
    parameter bit QUALIFY = 1'b1
) (
    input wire logic in_valid,
    input wire logic [BEAT_W-1:0] in_beat,
    input wire logic others_ready,
    output logic out_valid,
    output logic [BEAT_W-1:0] out_beat
);

    // The beat passes as wires, so the lane adds no cycle.
    assign out_beat = in_beat;

    // Gating keeps sinks from taking a beat that the source will repeat.
    assign out_valid = QUALIFY ? (in_valid & others_ready)
                               : in_valid;

endmodule // spl_lane

// File: test/spl_sink_model.sv
/*
 * Model of the downstream sinks of the stream splitter.
 * Assumes one clock shared with the splitter; ready is driven just after
 * each rising edge, so the splitter sees it settled before the next edge.
 */
`timescale 1ns/100ps

module spl_sink_model #(
    parameter int N = 4,
    parameter logic [31:0] SEED = 32'h0000_5a5b
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall_en,
    output logic [N-1:0] out_ready
);
    logic [31:0] s_q;

    // Each sink stalls about a quarter of the time, so whole-group
    // acceptance stays frequent enough to exercise the counters.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= SEED;
            out_ready <= '0;
        end else begin
            s_q <= {s_q[30:0], s_q[31] ^ s_q[21] ^ s_q[1] ^ s_q[0]};
            out_ready <= stall_en ? (s_q[N-1:0] | s_q[2*N-1:N]) : '1;
        end
    end
endmodule // spl_sink_model

// File: test/stream_splitter_tb_top.sv
/*
 * Self-checking bench of the stream splitter: random beats, random sink
 * stalls, a gated and an ungated instance, and the status port.
 * Assumes the splitter and the sink model under logic/ and test/.
 */
`timescale 1ns/100ps

module stream_splitter_tb_top;
    import spl_pkg::*;
    localparam int N = 4;
    localparam int BW = 24;
    localparam int DW = 16;
    localparam int CHW = 3;
    localparam int MAXCH = 5;
    localparam int ERW = 2;
    localparam bit ON = 1'b1;
    localparam bit OFF = 1'b0;
    logic clk_sys, rst, in_valid, in_ready, rdy_b, stall_en, run;
    logic [BW-1:0] in_beat;
    logic [N-1:0] out_valid, out_ready, val_b;
    logic [N-1:0][BW-1:0] out_beat, beat_b;
    spl_reg_req_t reg_req;
    logic [SPL_WORD_W-1:0] reg_rdata, rdata_b;
    logic [31:0] seed = 32'ha3d4;
    int failures, n_tests, n_beat, n_stall;
    bit cnt_en;

    spl_stream_splitter #(.OUTPUT_COUNT(N), .DATA_W(DW), .USE_PACKETS(ON),
        .USE_CHANNEL(ON), .CHANNEL_W(CHW), .MAX_CHANNELS(MAXCH),
        .USE_ERROR(ON), .ERROR_W(ERW)) dut (.clk_sys(clk_sys), .rst(rst),
        .in_valid(in_valid), .in_beat(in_beat), .in_ready(in_ready),
        .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready),
        .reg_req(reg_req), .reg_rdata(reg_rdata));
    // The ungated twin sees the same traffic and the same register accesses.
    spl_stream_splitter #(.OUTPUT_COUNT(N), .QUALIFY_VALID(OFF), .DATA_W(DW),
        .USE_PACKETS(ON), .USE_CHANNEL(ON), .CHANNEL_W(CHW),
        .MAX_CHANNELS(MAXCH), .USE_ERROR(ON), .ERROR_W(ERW)) dut_b (
        .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
        .in_beat(in_beat), .in_ready(rdy_b), .out_valid(val_b),
        .out_beat(beat_b), .out_ready(out_ready), .reg_req(reg_req),
        .reg_rdata(rdata_b));
    spl_sink_model #(.N(N)) sinks (.clk_sys(clk_sys), .rst(rst),
        .stall_en(stall_en), .out_ready(out_ready));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        reg_req <= '0;
        // Let the idle value stand one edge so a following request is not
        // assigned in the same time step.
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] e_b;
        e_b = e ^ (32'(a == SPL_OFS_CONFIG) << SPL_CFG_QUALIFY_BIT);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys);
        reg_req <= '0;
        @(negedge clk_sys);
        chk($sformatf("reg %h", a), e, reg_rdata);
        chk($sformatf("reg_b %h", a), e_b, rdata_b);
        @(posedge clk_sys);
    endtask

    // ************************************************************
    // Stimulus and reference model
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        seed = lfsr(seed);
        in_valid <= run & (seed[0] | seed[1]);
        in_beat <= seed[BW+3:4];
        if (!rst && cnt_en && in_valid && (&out_ready))
            n_beat++;
        if (!rst && cnt_en && in_valid && !(&out_ready))
            n_stall++;
    end

    // Outputs are wires of the inputs, so they are judged in the same cycle.
    always @(negedge clk_sys) begin
        if (!rst) begin
            chk("in_ready", {31'h0, &out_ready}, {31'h0, in_ready});
            chk("in_ready_b", {31'h0, &out_ready}, {31'h0, rdy_b});
            chk("valid_b", {28'h0, {N{in_valid}}}, {28'h0, val_b});
            for (int i = 0; i < N; i++) begin
                chk("beat", {8'h0, in_beat}, {8'h0, out_beat[i]});
                chk("beat_b", {8'h0, in_beat}, {8'h0, beat_b[i]});
                chk("valid", {31'h0, in_valid & (&(out_ready | (4'h1 << i)))},
                    {31'h0, out_valid[i]});
            end
        end
    end

    initial begin
        #(8 * 3000);
        failures++;
        conclude();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        run = 1'b0;
        stall_en = 1'b0;
        reg_req = '0;
        cnt_en = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(SPL_OFS_CONFIG, 32'h0502_3f04);
        rd(SPL_OFS_CTRL, 32'h0000_0001);
        rd(8'h20, 32'h0000_0000);
        wr(SPL_OFS_CONFIG, 32'h0000_0000);
        rd(SPL_OFS_CONFIG, 32'h0502_3f04);
        run <= 1'b1;
        repeat (20) @(posedge clk_sys);
        stall_en <= 1'b1;
        repeat (300) @(posedge clk_sys);
        run <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(SPL_OFS_BEATS, n_beat);
        rd(SPL_OFS_STALLS, n_stall);
        wr(SPL_OFS_CTRL, 32'h0000_0002);
        n_beat = 0;
        n_stall = 0;
        cnt_en = 1'b0;
        rd(SPL_OFS_BEATS, 32'h0000_0000);
        rd(SPL_OFS_CTRL, 32'h0000_0000);
        run <= 1'b1;
        repeat (40) @(posedge clk_sys);
        run <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(SPL_OFS_STALLS, 32'h0000_0000);
        conclude();
    end
endmodule // stream_splitter_tb_top
